// >>> shared/gpd_cfg.svh
`ifndef GPD_CFG_SVH
`define GPD_CFG_SVH

// ----------------------------------------
// port geometry
// ----------------------------------------
`define GPD_WIDTH      8
`define GPD_ADDR_W     2

// ----------------------------------------
// register offsets (register index)
// ----------------------------------------
`define GPD_OFS_DIR    2'h0
`define GPD_OFS_LATCH  2'h1
`define GPD_OFS_PIN    2'h2

// ----------------------------------------
// reset values and read patterns
// ----------------------------------------
`define GPD_DIR_RST    8'h00
`define GPD_LATCH_RST  8'h00
`define GPD_OE_N_RST   8'hFF
`define GPD_DIR_RDVAL  8'hA5
`define GPD_UNMAP_RD   8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define GPD_SYNC_STAGES 3

`endif

// >>> shared/gpd_pkg.sv
`include "gpd_cfg.svh"

package gpd_pkg;

   // ----------------------------------------
   // register bus request, one cycle long
   // ----------------------------------------
   typedef struct packed {
      logic                   wr;
      logic                   rd;
      logic [`GPD_ADDR_W-1:0] addr;
      logic [`GPD_WIDTH-1:0]  wdata;
   } gpd_bus_req_t;

   // ----------------------------------------
   // all state of the port block outside the pin synchroniser
   // ----------------------------------------
   typedef struct packed {
      logic [`GPD_WIDTH-1:0] dir;
      logic [`GPD_WIDTH-1:0] oe_n;
      logic [`GPD_WIDTH-1:0] latch;
      logic [`GPD_WIDTH-1:0] rdata;
   } gpd_state_t;

endpackage

// >>> rtl/gpd_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module gpd_pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level
);

   // ----------------------------------------
   // state: three stages plus accepted level
   // ----------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } gpd_sync_t;

   gpd_sync_t sync_ff;
   gpd_sync_t nxt_sync;

   // s1 feeds only s2; a level is accepted once s2 and s3 agree
   always_comb begin
      nxt_sync    = sync_ff;
      nxt_sync.s1 = pin_in;
      nxt_sync.s2 = sync_ff.s1;
      nxt_sync.s3 = sync_ff.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_ff.s2[i] == sync_ff.s3[i]) begin
            nxt_sync.lvl[i] = sync_ff.s3[i];
         end
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (reset) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign level = sync_ff.lvl;

endmodule

`default_nettype wire

// >>> rtl/gpd_port.sv
`timescale 1ns/1ns
`default_nettype none

`include "gpd_cfg.svh"

module gpd_port
   import gpd_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire gpd_bus_req_t          bus_req,
   output logic      [`GPD_WIDTH-1:0] rdata,
   input  wire logic [`GPD_WIDTH-1:0] pin_in,
   output logic      [`GPD_WIDTH-1:0] pin_out,
   output logic      [`GPD_WIDTH-1:0] pin_oe_n
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   gpd_state_t            st_ff;
   gpd_state_t            nxt_st;
   logic [`GPD_WIDTH-1:0] pin_level;

   logic                  wr_dir;
   logic                  wr_latch;
   logic                  rd_dir;
   logic                  rd_latch;
   logic                  rd_pin;

   // ----------------------------------------
   // pin input synchroniser
   // ----------------------------------------
   // pins are asynchronous to clock, so every pin
   // level passes three stages before software sees it
   gpd_pin_sync #(
      .WIDTH (`GPD_WIDTH)
   ) u_sync (
      .clock  (clock),
      .reset  (reset),
      .pin_in (pin_in),
      .level  (pin_level)
   );

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // strobes never overlap, so no priority between them
   always_comb begin
      wr_dir   = 1'b0;
      wr_latch = 1'b0;
      rd_dir   = 1'b0;
      rd_latch = 1'b0;
      rd_pin   = 1'b0;
      if (bus_req.addr == `GPD_OFS_DIR) begin
         wr_dir = bus_req.wr;
         rd_dir = bus_req.rd;
      end else if (bus_req.addr == `GPD_OFS_LATCH) begin
         wr_latch = bus_req.wr;
         rd_latch = bus_req.rd;
      end else if (bus_req.addr == `GPD_OFS_PIN) begin
         rd_pin = bus_req.rd;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_st       = st_ff;
      // read data stands for one cycle only
      nxt_st.rdata = '0;

      // a whole byte is taken on every direction or latch write; no bit
      // access exists, so a bit instruction is software's
      // own read-alter-write of the full byte
      if (wr_dir) begin
         nxt_st.dir  = bus_req.wdata;
         // enable is active low: 1 in direction drives the pin
         nxt_st.oe_n = ~bus_req.wdata;
      end

      // latch is written whatever the direction; it
      // reaches the pin once the pin becomes an output
      if (wr_latch) begin
         nxt_st.latch = bus_req.wdata;
      end

      // read return; the stored direction is never shown,
      // so a bit instruction on it corrupts other bits
      if (rd_dir) begin
         nxt_st.rdata = `GPD_DIR_RDVAL;
      end else if (rd_latch) begin
         nxt_st.rdata = st_ff.latch;
      end else if (rd_pin) begin
         // true pin level, also for output pins
         nxt_st.rdata = pin_level;
      end else if (bus_req.rd) begin
         nxt_st.rdata = `GPD_UNMAP_RD;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // synchronous reset: every pin lets go on the first
   // edge that sees reset, before any software access
   always_ff @(posedge clock) begin
      if (reset) begin
         st_ff.dir   <= `GPD_DIR_RST;
         st_ff.oe_n  <= `GPD_OE_N_RST;
         st_ff.latch <= `GPD_LATCH_RST;
         st_ff.rdata <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // outputs, straight from flip-flops
   // ----------------------------------------
   // no logic after the flops, so the pins carry no
   // decode glitches while the bus is busy
   // eight pins, each with its own enable
   assign pin_out  = st_ff.latch;
   assign pin_oe_n = st_ff.oe_n;
   assign rdata    = st_ff.rdata;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking

   default disable iff (reset);

   // ----------------------------------------
   // bus request shapes
   // ----------------------------------------
   // a write of the direction register
   sequence dir_wr_s;
      bus_req.wr && bus_req.addr == `GPD_OFS_DIR;
   endsequence

   // a write of the output latch
   sequence latch_wr_s;
      bus_req.wr && bus_req.addr == `GPD_OFS_LATCH;
   endsequence

   // a read of the pin-state register
   sequence pin_rd_s;
      bus_req.rd && bus_req.addr == `GPD_OFS_PIN;
   endsequence

   // a read of the direction register
   sequence dir_rd_s;
      bus_req.rd && bus_req.addr == `GPD_OFS_DIR;
   endsequence

   // a read of the output latch
   sequence latch_rd_s;
      bus_req.rd && bus_req.addr == `GPD_OFS_LATCH;
   endsequence

   // a read of the unused fourth index
   sequence unmap_rd_s;
      bus_req.rd && bus_req.addr == 2'h3;
   endsequence

   // ----------------------------------------
   // write checks
   // ----------------------------------------
   // active-low enables are the inverse of the written byte one cycle on
   property dir_write_p;
      logic [`GPD_WIDTH-1:0] d;
      (dir_wr_s, d = bus_req.wdata) |=> pin_oe_n == ~d;
   endproperty

   dir_write_out_a: assert property (dir_write_p)
      else $error("direction write did not enable the outputs");

   // all-zero direction releases every pin
   dir_input_a: assert property (
      dir_wr_s ##0 (bus_req.wdata == '0) |=> pin_oe_n == `GPD_OE_N_RST)
      else $error("zero direction left a pin driven");

   // enables only move after a direction write
   dir_hold_a: assert property (
      !bus_req.wr && !$past(reset) |=> $stable(pin_oe_n))
      else $error("pin enable changed without a direction write");

   // direction reads never expose the stored setting
   dir_hidden_a: assert property (
      dir_rd_s |=> rdata == `GPD_DIR_RDVAL)
      else $error("direction read did not return the fixed pattern");

   // latch reaches the pin on the next cycle
   property latch_drive_p;
      logic [`GPD_WIDTH-1:0] d;
      (latch_wr_s, d = bus_req.wdata) |=> pin_out == d;
   endproperty

   latch_drive_a: assert property (latch_drive_p)
      else $error("output latch did not reach the pins");

   // pin read returns the accepted level
   property pin_read_p;
      logic [`GPD_WIDTH-1:0] v;
      (pin_rd_s, v = pin_level) |=> rdata == v;
   endproperty

   pin_read_a: assert property (pin_read_p)
      else $error("pin-state read returned a wrong level");

   // read data stands one cycle, then drops
   rdata_pulse_a: assert property (
      !bus_req.rd |=> rdata == '0)
      else $error("read data stood past its cycle");

   // two back-to-back direction writes, the last one counts
   dir_last_a: assert property (
      dir_wr_s ##1 (dir_wr_s and bus_req.wdata == '1)
      |=> pin_oe_n == '0)
      else $error("second direction write was lost");

   // a latch write leaves the pin directions alone
   latch_keeps_dir_a: assert property (
      latch_wr_s |=> $stable(pin_oe_n))
      else $error("latch write moved a pin enable");

   // a direction write leaves the output latch alone
   dir_keeps_latch_a: assert property (
      dir_wr_s |=> $stable(pin_out))
      else $error("direction write moved the output latch");

   // ----------------------------------------
   // read return and hold checks
   // ----------------------------------------
   // latch reads give back the byte held for the pins
   property latch_read_p;
      logic [`GPD_WIDTH-1:0] v;
      (latch_rd_s, v = pin_out) |=> rdata == v;
   endproperty

   latch_read_a: assert property (latch_read_p)
      else $error("output latch read returned a wrong byte");

   // the unused index reads as a fixed quiet value
   unmap_read_a: assert property (
      unmap_rd_s |=> rdata == `GPD_UNMAP_RD)
      else $error("unmapped read returned a wrong byte");

   // a direction read leaves the enables as they are
   dir_read_keep_a: assert property (
      dir_rd_s |=> $stable(pin_oe_n))
      else $error("direction read moved a pin enable");

   // pins keep their latch value until the latch is written;
   // a stray change here reaches outside circuitry at once
   latch_hold_a: assert property (
      !(bus_req.wr && bus_req.addr == `GPD_OFS_LATCH) |=> $stable(pin_out))
      else $error("output latch changed without a latch write");

   // writes to the pin-state index must not disturb the port
   pin_wr_ignored_a: assert property (
      bus_req.wr && bus_req.addr == `GPD_OFS_PIN
      |=> $stable(pin_out) && $stable(pin_oe_n))
      else $error("pin-state write disturbed latch or enables");

   // enable flops mirror the direction bits; they are kept
   // apart so the pin enable comes straight from a flop
   oe_mirror_a: assert property (
      pin_oe_n == ~st_ff.dir)
      else $error("pin enable disagrees with the direction bits");

   // ----------------------------------------
   // reset behaviour, checked without disable
   // ----------------------------------------
   // the edge after reset leaves every pin released
   property reset_input_p;
      @(posedge clock) reset ##1 !bus_req.wr
         |-> pin_oe_n == `GPD_OE_N_RST && st_ff.dir == `GPD_DIR_RST;
   endproperty

   reset_input_a: assert property (disable iff (1'b0) reset_input_p)
      else $error("a pin was driven right after reset");

   // the latch and the read data are cleared by reset as well
   property reset_latch_p;
      @(posedge clock) reset |=> pin_out == `GPD_LATCH_RST && rdata == '0;
   endproperty

   reset_latch_a: assert property (disable iff (1'b0) reset_latch_p)
      else $error("latch or read data survived reset");

endmodule

`default_nettype wire

// >>> tb/gpd_ext_model.sv
`timescale 1ns/1ns
`default_nettype none

`include "gpd_cfg.svh"

// ----------------------------------------
// outside circuitry on the eight pins
// ----------------------------------------
module gpd_ext_model (
   input  wire logic                  clock,
   input  wire logic [`GPD_WIDTH-1:0] pin_out,
   input  wire logic [`GPD_WIDTH-1:0] pin_oe_n,
   input  wire logic [`GPD_WIDTH-1:0] ext_val,
   input  wire logic [`GPD_WIDTH-1:0] ext_en,
   output logic      [`GPD_WIDTH-1:0] pin_wire
);
   // undriven lines wander, so a stale level is never mistaken for a real one
   logic [`GPD_WIDTH-1:0] float_ff = 8'h55;

   always @(posedge clock) begin
      float_ff <= ~float_ff;
   end

   // device drive wins where it is enabled, else the outside drives where ext_en is set, else the line floats
   always_comb begin
      for (int i = 0; i < `GPD_WIDTH; i++) begin
         pin_wire[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : float_ff[i]);
      end
   end
endmodule

`default_nettype wire

// >>> tb/gpd_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

`include "gpd_cfg.svh"

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module gpd_port_tb;
   import gpd_pkg::*;

   logic                  clock = 1'b0;
   logic                  reset = 1'b1;
   gpd_bus_req_t          bus_req = '0;
   logic [`GPD_WIDTH-1:0] rdata;
   logic [`GPD_WIDTH-1:0] pin_out;
   logic [`GPD_WIDTH-1:0] pin_oe_n;
   logic [`GPD_WIDTH-1:0] pin_wire;
   logic [`GPD_WIDTH-1:0] ext_val = 8'h3A;
   logic [`GPD_WIDTH-1:0] ext_en = 8'hFF;
   int                    miscompares = 0;
   int                    checks = 0;
   int                    cycles = 0;

   always #50 clock = ~clock;

   gpd_port u_gpd_port (.clock(clock), .reset(reset), .bus_req(bus_req), .rdata(rdata),
      .pin_in(pin_wire), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

   gpd_ext_model u_gpd_ext_model (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_val(ext_val), .ext_en(ext_en), .pin_wire(pin_wire));

   // ----------------------------------------
   // bus tasks and closing
   // ----------------------------------------
   // one idle cycle after each strobe keeps a single driver per time step
   task automatic wr_reg(input logic [`GPD_ADDR_W-1:0] a, input logic [`GPD_WIDTH-1:0] d);
      @(posedge clock) bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge clock) bus_req <= '0;
      #1;
   endtask

   // two writes with no gap between them, as the bus allows
   task automatic wr_pair(input logic [`GPD_ADDR_W-1:0] a, input logic [`GPD_WIDTH-1:0] d1,
      input logic [`GPD_WIDTH-1:0] d2);
      @(posedge clock) bus_req <= '{1'b1, 1'b0, a, d1};
      @(posedge clock) bus_req <= '{1'b1, 1'b0, a, d2};
      @(posedge clock) bus_req <= '0;
      #1;
   endtask

   task automatic rd_reg(input logic [`GPD_ADDR_W-1:0] a, input logic [`GPD_WIDTH-1:0] ex, input string nm);
      @(posedge clock) bus_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock) bus_req <= '0;
      #1;
      `CHK(nm, ex, rdata)
      @(posedge clock) #1;
      `CHK("rdata idle", 8'h00, rdata)
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // hang guard, far beyond the fewer than a hundred cycles of the sequence
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         report_and_stop;
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      #1;
      `CHK("oe after reset", 8'hFF, pin_oe_n)
      `CHK("out after reset", 8'h00, pin_out)
      rd_reg(`GPD_OFS_DIR, `GPD_DIR_RDVAL, "dir read");
      rd_reg(`GPD_OFS_PIN, 8'h3A, "pins all input");
      // whole-byte direction writes only, from a software shadow copy
      wr_reg(`GPD_OFS_DIR, 8'hF0);
      `CHK("oe dir F0", 8'h0F, pin_oe_n)
      rd_reg(`GPD_OFS_DIR, `GPD_DIR_RDVAL, "dir read F0");
      wr_reg(`GPD_OFS_LATCH, 8'hD5);
      `CHK("latch out", 8'hD5, pin_out)
      rd_reg(`GPD_OFS_LATCH, 8'hD5, "latch read");
      rd_reg(`GPD_OFS_PIN, 8'hDA, "mixed pins");
      // outside change reaches only input pins, after the sync delay
      @(posedge clock) ext_val <= 8'h25;
      repeat (4) @(posedge clock);
      rd_reg(`GPD_OFS_PIN, 8'hD5, "pins changed");
      // bit clear of pin 4 as read of shadow, change, full write back
      wr_reg(`GPD_OFS_DIR, 8'hE0);
      `CHK("oe dir E0", 8'h1F, pin_oe_n)
      // pin 4 now follows the outside; let the sync stages settle
      repeat (`GPD_SYNC_STAGES) @(posedge clock);
      rd_reg(`GPD_OFS_PIN, 8'hC5, "pin4 input");
      // pin-state and unmapped writes leave the latch alone
      wr_reg(`GPD_OFS_PIN, 8'hFF);
      wr_reg(2'h3, 8'h0F);
      rd_reg(`GPD_OFS_LATCH, 8'hD5, "latch kept");
      rd_reg(2'h3, `GPD_UNMAP_RD, "unmapped read");
      wr_pair(`GPD_OFS_DIR, 8'h0F, 8'hFF);
      `CHK("oe back to back", 8'h00, pin_oe_n)
      wr_reg(`GPD_OFS_DIR, 8'hFF);
      `CHK("oe all out", 8'h00, pin_oe_n)
      // pin 4 turned back to an output; wait out the sync stages
      repeat (`GPD_SYNC_STAGES) @(posedge clock);
      rd_reg(`GPD_OFS_PIN, 8'hD5, "all driven");
      wr_reg(`GPD_OFS_DIR, 8'h00);
      `CHK("oe all in", 8'hFF, pin_oe_n)
      // second reset in mid-run with outputs enabled
      wr_reg(`GPD_OFS_DIR, 8'h0F);
      @(posedge clock) reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      #1;
      `CHK("oe mid reset", 8'hFF, pin_oe_n)
      `CHK("out mid reset", `GPD_LATCH_RST, pin_out)
      rd_reg(`GPD_OFS_LATCH, `GPD_LATCH_RST, "latch mid reset");
      repeat (4) @(posedge clock);
      rd_reg(`GPD_OFS_PIN, 8'h25, "pins after reset");
      // an undriven input wanders every cycle; the sync keeps its last level
      @(posedge clock) ext_en <= 8'hFE;
      repeat (4) @(posedge clock);
      rd_reg(`GPD_OFS_PIN, 8'h25, "pin0 floating");
      report_and_stop;
   end
endmodule

`default_nettype wire
